// ==== inc/dis_defines.svh ====
// Timing counts and opcode codes for the dual-issue scoreboard.
// Assumes 6-bit major opcodes and 7-bit cycle counters.
`ifndef DIS_DEFINES_SVH
`define DIS_DEFINES_SVH
`define DIS_REG_ZERO    5'h1F
`define DIS_AGE_MAX     7'h7F
`define DIS_MUL_OCC_L   7'h13
`define DIS_MUL_OCC_Q   7'h15
`define DIS_MUL_RES_L   7'h15
`define DIS_MUL_RES_Q   7'h17
`define DIS_DIV_OCC_S   7'h1E
`define DIS_DIV_OCC_T   7'h3B
`define DIS_DIV_RES_S   7'h22
`define DIS_DIV_RES_T   7'h3F
`define DIS_LD_DONE     7'h03
`define DIS_MUL_GUARD   7'h03
`define DIS_DIV_GUARD_A 7'h05
`define DIS_DIV_GUARD_B 7'h06
`define DIS_STC_HOLD    2'h2
`define DIS_OP_MISC     6'h18
`define DIS_OP_MFPR     6'h19
`define DIS_OP_JUMP     6'h1A
`define DIS_OP_MTPR     6'h1D
`define DIS_OP_EXC_RET  6'h1E
`define DIS_OP_BR       6'h30
`define DIS_OP_BSR      6'h34
`define DIS_OP_STL_C    6'h2E
`define DIS_OP_STQ_C    6'h2F
`endif

// ==== inc/dis_pkg.sv ====
// Types shared by the dual-issue scoreboard.
// Assumes the decode stage classifies each instruction.
package dis_pkg;
  typedef enum logic [3:0] {
    LOAD_CLASS, STORE_CLASS, INT_COND_BRANCH_CLASS, FP_COND_BRANCH_CLASS, JUMP_CLASS,
    ADD_LOGIC_CLASS, SHIFT_CMOV_CLASS, INT_COMPARE_CLASS, MUL_LONG_CLASS, MUL_QUAD_CLASS,
    FP_OPERATE_CLASS, FP_DIVIDE_S_CLASS, FP_DIVIDE_T_CLASS, NONE_CLASS
  } dis_cls_t;
  typedef enum logic [1:0] {ISSUE_BUS_ZERO, ISSUE_BUS_ONE, ISSUE_BUS_EITHER} dis_bus_t;
  typedef enum logic [1:0] {MISC_OTHER, MEMORY_BARRIER, TRAP_BARRIER} dis_misc_t;
  typedef struct packed {
    logic [63:0]           pend;
    logic [63:0]           wait_fill;
    logic [63:0][6:0]      age;
    dis_cls_t [63:0]       cls;
    logic [6:0]            mul_occ;
    logic [6:0]            mul_res;
    logic [6:0]            div_occ;
    logic [6:0]            div_res;
    logic [1:0]            stc_hold;
    logic                  mb_wait;
    logic                  jmp_last;
  } dis_state_t;
endpackage : dis_pkg

// ==== design/dis_scoreboard.sv ====
// Issue-stage scoreboard for a dual-issue pipeline: latency, ordering, structural and pairing checks.
// Assumes decode presents up to two in-order instructions and drops the ones reported issued.
// Functional notes
// RULE1: consumer waits N cycles after producer issue
// RULE2: fixed class-pair latency matrix stalls consumers
// RULE3: load miss holds consumer until fill
// RULE4: separate store base and data latencies
// RULE5: dependent multiply/divide longer, else occupancy
// RULE6: shift to add waits two, inserts nop
// RULE7: zero latency allows same-cycle pair
// RULE8: long producers block same-destination writers; the code skips this check between the two slots of one pair
// RULE9: issue only with clean sources and destination
// RULE10: barrier holds memory-type instructions until acknowledged
// RULE11: multiplier busy; guard three before completion
// RULE12: no conditional branch right after jump
// RULE13: trap barrier never second of pair
// RULE14: no loads two cycles after store-conditional
// RULE15: busy load/store unit holds memory set
// RULE16: divider busy; guard five/six before completion
// RULE17: dual issue only within aligned quadword
// RULE18: bus groups must not collide
// RULE19: at most one control transfer per pair
// RULE20: at most one memory/special per pair
// RULE21: opcode maps to issue-bus group
// RULE22: blocked instruction holds, issued ones advance
`timescale 1ns/1ns
`include "dis_defines.svh"
module dis_scoreboard
  import dis_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       s0_vld,
  input  wire logic [5:0] s0_opc,
  input  dis_cls_t        s0_cls,
  input  dis_misc_t       s0_misc,
  input  wire logic [5:0] s0_ra,
  input  wire logic [5:0] s0_rb,
  input  wire logic [5:0] s0_rc,
  input  wire logic       s0_ra_use,
  input  wire logic       s0_rb_use,
  input  wire logic       s0_rc_use,
  input  wire logic       s1_vld,
  input  wire logic [5:0] s1_opc,
  input  dis_cls_t        s1_cls,
  input  dis_misc_t       s1_misc,
  input  wire logic [5:0] s1_ra,
  input  wire logic [5:0] s1_rb,
  input  wire logic [5:0] s1_rc,
  input  wire logic       s1_ra_use,
  input  wire logic       s1_rb_use,
  input  wire logic       s1_rc_use,
  input  wire logic       pair_same_qw,
  input  wire logic       mb_ack,
  input  wire logic       lsu_busy,
  input  wire logic       lsu_miss,
  input  wire logic [5:0] lsu_miss_reg,
  input  wire logic       lsu_fill,
  input  wire logic [5:0] lsu_fill_reg,
  output logic            issue0,
  output logic            issue1,
  output logic            issue_hold,
  output logic            nop_inject
);

  // Rows: consumer LD, ST base, INT_COND_BRANCH_CLASS, JUMP_CLASS, ADD, SHIFT, INT_COMPARE_CLASS, INT_MULTIPLY_CLASS, FP_COND_BRANCH_CLASS, FP_OPERATE_CLASS, FP_DIVIDE_CLASS, ST data.
  // Columns: producer LD, JUMP_CLASS, ADD, SHIFT, INT_COMPARE_CLASS, MULL, MULQ, FP_OPERATE_CLASS, FP_DIVIDE_CLASS S, FP_DIVIDE_CLASS T.
  // Impossible pairs read as zero; decode never presents them.
  localparam logic [6:0] LAT [12][10] = '{
    '{7'h03, 7'h03, 7'h02, 7'h02, 7'h02, 7'h15, 7'h17, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h02, 7'h02, 7'h15, 7'h15, 7'h17, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h01, 7'h02, 7'h01, 7'h15, 7'h17, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h02, 7'h02, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h01, 7'h02, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h01, 7'h02, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h01, 7'h02, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h03, 7'h01, 7'h02, 7'h02, 7'h15, 7'h17, 7'h00, 7'h00, 7'h00},
    '{7'h03, 7'h00, 7'h00, 7'h00, 7'h00, 7'h02, 7'h02, 7'h06, 7'h22, 7'h3F},
    '{7'h03, 7'h00, 7'h00, 7'h00, 7'h00, 7'h02, 7'h02, 7'h06, 7'h22, 7'h3F},
    '{7'h03, 7'h00, 7'h00, 7'h00, 7'h00, 7'h02, 7'h02, 7'h06, 7'h22, 7'h3F},
    '{7'h03, 7'h03, 7'h00, 7'h00, 7'h14, 7'h14, 7'h16, 7'h04, 7'h20, 7'h3D}
  };

  dis_state_t state_ff;
  dis_state_t nxt_state;

  // RULE2: class-pair latency lookup
  // RULE4: store data row separate from base
  function automatic logic [6:0] lat_of(input dis_cls_t prod, input dis_cls_t cons, input logic st_data);
    logic [3:0] row;
    logic [3:0] col;
    row = 4'h0;
    col = 4'h0;
    unique case (cons)
      STORE_CLASS:                          row = st_data ? 4'hB : 4'h1;
      INT_COND_BRANCH_CLASS:                row = 4'h2;
      JUMP_CLASS:                           row = 4'h3;
      ADD_LOGIC_CLASS:                      row = 4'h4;
      SHIFT_CMOV_CLASS:                     row = 4'h5;
      INT_COMPARE_CLASS:                    row = 4'h6;
      MUL_LONG_CLASS, MUL_QUAD_CLASS:       row = 4'h7;
      FP_COND_BRANCH_CLASS:                 row = 4'h8;
      FP_OPERATE_CLASS:                     row = 4'h9;
      FP_DIVIDE_S_CLASS, FP_DIVIDE_T_CLASS: row = 4'hA;
      default:                              row = 4'h0;
    endcase
    unique case (prod)
      JUMP_CLASS:        col = 4'h1;
      ADD_LOGIC_CLASS:   col = 4'h2;
      SHIFT_CMOV_CLASS:  col = 4'h3;
      INT_COMPARE_CLASS: col = 4'h4;
      MUL_LONG_CLASS:    col = 4'h5;
      MUL_QUAD_CLASS:    col = 4'h6;
      FP_OPERATE_CLASS:  col = 4'h7;
      FP_DIVIDE_S_CLASS: col = 4'h8;
      FP_DIVIDE_T_CLASS: col = 4'h9;
      default:           col = 4'h0;
    endcase
    return LAT[row][col];
  endfunction : lat_of

  // RULE21: opcode to issue-bus group
  function automatic dis_bus_t bus_of(input logic [5:0] op);
    dis_bus_t b;
    b = ISSUE_BUS_ONE;
    if (op == 6'h08 || op == 6'h09 || (op >= 6'h10 && op <= 6'h13) || (op >= 6'h24 && op <= 6'h27) ||
        (op >= 6'h31 && op <= 6'h33) || (op >= 6'h35 && op <= 6'h37)) begin
      b = ISSUE_BUS_ZERO;
    end else if (op == 6'h0B || (op >= 6'h20 && op <= 6'h23) || (op >= 6'h28 && op <= 6'h2B)) begin
      b = ISSUE_BUS_EITHER;
    end
    return b;
  endfunction : bus_of

  // Cycles until a long producer's own write lands; zero for short ones.
  function automatic logic [6:0] done_of(input dis_cls_t c);
    unique case (c)
      LOAD_CLASS:        return `DIS_LD_DONE;
      MUL_LONG_CLASS:    return `DIS_MUL_RES_L;
      MUL_QUAD_CLASS:    return `DIS_MUL_RES_Q;
      FP_DIVIDE_S_CLASS: return `DIS_DIV_RES_S;
      FP_DIVIDE_T_CLASS: return `DIS_DIV_RES_T;
      default:           return 7'h00;
    endcase
  endfunction : done_of

  // RULE1: ready once age reaches latency
  // RULE3: miss-marked entries wait for fill
  function automatic logic src_ok(input dis_state_t st, input logic [5:0] r, input dis_cls_t cons,
                                  input logic st_data);
    return (r[4:0] == `DIS_REG_ZERO) || !st.pend[r] ||
           (!st.wait_fill[r] && st.age[r] >= lat_of(st.cls[r], cons, st_data));
  endfunction : src_ok

  logic [1:0]       vld;
  logic [1:0][5:0]  opc;
  dis_cls_t [1:0]   cls;
  dis_misc_t [1:0]  misc;
  logic [1:0][5:0]  ra;
  logic [1:0][5:0]  rb;
  logic [1:0][5:0]  rc;
  logic [1:0]       ra_use;
  logic [1:0]       rb_use;
  logic [1:0]       rc_use;
  logic [1:0]       is_ld;
  logic [1:0]       is_st;
  logic [1:0]       is_ctl;
  logic [1:0]       is_mem1;
  logic [1:0]       is_hold;
  logic [1:0]       is_mul;
  logic [1:0]       is_div;
  logic [1:0]       is_mb;
  logic [1:0]       ok;
  logic             pair_ok;
  logic             shift_add;

  assign vld    = {s1_vld, s0_vld};
  assign opc    = {s1_opc, s0_opc};
  // Per element: enum slots refuse a plain concatenated vector
  assign cls[0]  = s0_cls;
  assign cls[1]  = s1_cls;
  assign misc[0] = s0_misc;
  assign misc[1] = s1_misc;
  assign ra     = {s1_ra, s0_ra};
  assign rb     = {s1_rb, s0_rb};
  assign rc     = {s1_rc, s0_rc};
  assign ra_use = {s1_ra_use, s0_ra_use};
  assign rb_use = {s1_rb_use, s0_rb_use};
  assign rc_use = {s1_rc_use, s0_rc_use};

  always_comb begin
    shift_add = 1'b0;
    for (int i = 0; i < 2; i++) begin
      is_ld[i]   = cls[i] == LOAD_CLASS;
      is_st[i]   = cls[i] == STORE_CLASS;
      is_mul[i]  = cls[i] == MUL_LONG_CLASS || cls[i] == MUL_QUAD_CLASS;
      is_div[i]  = cls[i] == FP_DIVIDE_S_CLASS || cls[i] == FP_DIVIDE_T_CLASS;
      is_mb[i]   = opc[i] == `DIS_OP_MISC && misc[i] == MEMORY_BARRIER;
      is_ctl[i]  = opc[i] == `DIS_OP_JUMP || opc[i] == `DIS_OP_EXC_RET || opc[i][5:4] == 2'h3;
      is_mem1[i] = is_ld[i] || is_st[i] || opc[i] == `DIS_OP_MFPR || opc[i] == `DIS_OP_MTPR ||
                   opc[i] == `DIS_OP_MISC || opc[i] == `DIS_OP_EXC_RET || opc[i] == `DIS_OP_BR ||
                   opc[i] == `DIS_OP_BSR || opc[i] == `DIS_OP_JUMP;
      is_hold[i] = is_ld[i] || is_st[i] || opc[i] == `DIS_OP_MISC || opc[i] == `DIS_OP_MFPR ||
                   opc[i] == `DIS_OP_MTPR ||
                   ((opc[i] == `DIS_OP_JUMP || opc[i] == `DIS_OP_BR || opc[i] == `DIS_OP_BSR) &&
                    rc_use[i] && rc[i][4:0] != `DIS_REG_ZERO);
      ok[i] = vld[i];
      // RULE9: sources clean or bypassable
      if (ra_use[i] && !src_ok(state_ff, ra[i], cls[i], is_st[i])) ok[i] = 1'b0;
      if (rb_use[i] && !src_ok(state_ff, rb[i], cls[i], 1'b0)) ok[i] = 1'b0;
      // RULE8: long producer orders same-destination writes
      if (rc_use[i] && rc[i][4:0] != `DIS_REG_ZERO && state_ff.pend[rc[i]] &&
          (state_ff.wait_fill[rc[i]] || state_ff.age[rc[i]] < done_of(state_ff.cls[rc[i]]))) ok[i] = 1'b0;
      // RULE10: barrier holds memory set
      // RULE15: busy load/store unit holds same set
      if (is_hold[i] && (state_ff.mb_wait || lsu_busy)) ok[i] = 1'b0;
      // RULE5: occupancy when not data dependent
      // RULE11: multiplier busy and completion guard
      if (is_mul[i] && state_ff.mul_occ != 7'h00) ok[i] = 1'b0;
      if ((cls[i] == SHIFT_CMOV_CLASS || cls[i] == ADD_LOGIC_CLASS || cls[i] == INT_COMPARE_CLASS) &&
          state_ff.mul_res == `DIS_MUL_GUARD) ok[i] = 1'b0;
      // RULE16: divider busy and completion guard
      if (is_div[i] && state_ff.div_occ != 7'h00) ok[i] = 1'b0;
      if (cls[i] == FP_OPERATE_CLASS &&
          (state_ff.div_res == `DIS_DIV_GUARD_A || state_ff.div_res == `DIS_DIV_GUARD_B)) ok[i] = 1'b0;
      // RULE12: no conditional branch after jump
      if ((cls[i] == INT_COND_BRANCH_CLASS || cls[i] == FP_COND_BRANCH_CLASS) && state_ff.jmp_last) ok[i] = 1'b0;
      // RULE14: loads blocked after store-conditional
      if (is_ld[i] && state_ff.stc_hold != 2'h0) ok[i] = 1'b0;
    end
    // RULE6: shift feeding add costs a nop cycle
    if (cls[0] == ADD_LOGIC_CLASS) begin
      if (ra_use[0] && state_ff.pend[ra[0]] && state_ff.cls[ra[0]] == SHIFT_CMOV_CLASS &&
          state_ff.age[ra[0]] < lat_of(SHIFT_CMOV_CLASS, ADD_LOGIC_CLASS, 1'b0)) shift_add = 1'b1;
      if (rb_use[0] && state_ff.pend[rb[0]] && state_ff.cls[rb[0]] == SHIFT_CMOV_CLASS &&
          state_ff.age[rb[0]] < lat_of(SHIFT_CMOV_CLASS, ADD_LOGIC_CLASS, 1'b0)) shift_add = 1'b1;
    end
    // RULE17: same aligned quadword only
    pair_ok = pair_same_qw;
    // RULE18: bus groups must not collide
    if (bus_of(opc[0]) != ISSUE_BUS_EITHER && bus_of(opc[0]) == bus_of(opc[1])) pair_ok = 1'b0;
    // RULE19: one control transfer per pair
    if (is_ctl[0] && is_ctl[1]) pair_ok = 1'b0;
    // RULE20: one memory or special per pair
    if (is_mem1[0] && is_mem1[1]) pair_ok = 1'b0;
    // RULE13: trap barrier never second
    if (opc[1] == `DIS_OP_MISC && misc[1] == TRAP_BARRIER) pair_ok = 1'b0;
    // RULE7: in-pair dependency only at zero latency
    if (rc_use[0] && rc[0][4:0] != `DIS_REG_ZERO) begin
      if (ra_use[1] && ra[1] == rc[0] && lat_of(cls[0], cls[1], is_st[1]) != 7'h00) pair_ok = 1'b0;
      if (rb_use[1] && rb[1] == rc[0] && lat_of(cls[0], cls[1], 1'b0) != 7'h00) pair_ok = 1'b0;
    end
  end

  // RULE22: blocked slot stays, upstream holds
  assign issue0     = ok[0];
  assign issue1     = ok[1] && (!vld[0] || (ok[0] && pair_ok));
  assign issue_hold = (vld[0] && !issue0) || (vld[1] && !issue1);
  assign nop_inject = vld[0] && !issue0 && shift_add;

  always_comb begin
    nxt_state = state_ff;
    for (int r = 0; r < 64; r++) begin
      if (nxt_state.age[r] != `DIS_AGE_MAX) nxt_state.age[r] = nxt_state.age[r] + 7'h01;
      if (nxt_state.age[r] == `DIS_AGE_MAX && !nxt_state.wait_fill[r]) nxt_state.pend[r] = 1'b0;
    end
    if (nxt_state.mul_occ != 7'h00) nxt_state.mul_occ = nxt_state.mul_occ - 7'h01;
    if (nxt_state.mul_res != 7'h00) nxt_state.mul_res = nxt_state.mul_res - 7'h01;
    if (nxt_state.div_occ != 7'h00) nxt_state.div_occ = nxt_state.div_occ - 7'h01;
    if (nxt_state.div_res != 7'h00) nxt_state.div_res = nxt_state.div_res - 7'h01;
    if (nxt_state.stc_hold != 2'h0) nxt_state.stc_hold = nxt_state.stc_hold - 2'h1;
    nxt_state.jmp_last = 1'b0;
    if (lsu_fill) nxt_state.wait_fill[lsu_fill_reg] = 1'b0;
    // RULE3: miss marks result late until fill
    if (lsu_miss) nxt_state.wait_fill[lsu_miss_reg] = 1'b1;
    if (mb_ack) nxt_state.mb_wait = 1'b0;
    // Issue updates come last so they override same-cycle age, miss, fill and ack updates
    for (int i = 0; i < 2; i++) begin
      if ((i == 0) ? issue0 : issue1) begin
        if (rc_use[i] && rc[i][4:0] != `DIS_REG_ZERO) begin
          nxt_state.pend[rc[i]]      = 1'b1;
          nxt_state.wait_fill[rc[i]] = 1'b0;
          nxt_state.age[rc[i]]       = 7'h01;
          nxt_state.cls[rc[i]]       = cls[i];
        end
        if (cls[i] == MUL_LONG_CLASS) begin
          nxt_state.mul_occ = `DIS_MUL_OCC_L - 7'h01;
          nxt_state.mul_res = `DIS_MUL_RES_L - 7'h01;
        end
        if (cls[i] == MUL_QUAD_CLASS) begin
          nxt_state.mul_occ = `DIS_MUL_OCC_Q - 7'h01;
          nxt_state.mul_res = `DIS_MUL_RES_Q - 7'h01;
        end
        if (cls[i] == FP_DIVIDE_S_CLASS) begin
          nxt_state.div_occ = `DIS_DIV_OCC_S - 7'h01;
          nxt_state.div_res = `DIS_DIV_RES_S - 7'h01;
        end
        if (cls[i] == FP_DIVIDE_T_CLASS) begin
          nxt_state.div_occ = `DIS_DIV_OCC_T - 7'h01;
          nxt_state.div_res = `DIS_DIV_RES_T - 7'h01;
        end
        if (opc[i] == `DIS_OP_STL_C || opc[i] == `DIS_OP_STQ_C) nxt_state.stc_hold = `DIS_STC_HOLD;
        if (opc[i] == `DIS_OP_JUMP || opc[i] == `DIS_OP_EXC_RET) nxt_state.jmp_last = 1'b1;
        if (is_mb[i]) nxt_state.mb_wait = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : dis_scoreboard

// ==== tb/dis_scoreboard_sva.sv ====
// Port-level checker for the dual-issue scoreboard.
// Assumes it is bound to dis_scoreboard and sees only its ports.
`timescale 1ns/1ns
module dis_scoreboard_sva
  import dis_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       s0_vld,
  input wire logic [5:0] s0_opc,
  input dis_cls_t        s0_cls,
  input dis_misc_t       s0_misc,
  input wire logic       s1_vld,
  input wire logic [5:0] s1_opc,
  input dis_cls_t        s1_cls,
  input dis_misc_t       s1_misc,
  input wire logic       pair_same_qw,
  input wire logic       lsu_busy,
  input wire logic       issue0,
  input wire logic       issue1,
  input wire logic       issue_hold,
  input wire logic       nop_inject
);
  logic ld0, ld1, st0, st1, cb0, cb1, jp0, jp1, ld_iss, stc_iss, jmp_iss, br_iss, both;
  // Loads sit at 20..23 and 28..2B, stores at 24..27 and 2C..2F
  always_comb begin
    ld0 = s0_opc[5:4] == 2'h2 && !s0_opc[2];
    ld1 = s1_opc[5:4] == 2'h2 && !s1_opc[2];
    st0 = s0_opc[5:4] == 2'h2 && s0_opc[2];
    st1 = s1_opc[5:4] == 2'h2 && s1_opc[2];
    cb0 = s0_cls inside {INT_COND_BRANCH_CLASS, FP_COND_BRANCH_CLASS};
    cb1 = s1_cls inside {INT_COND_BRANCH_CLASS, FP_COND_BRANCH_CLASS};
    jp0 = s0_opc inside {6'h1A, 6'h1E};
    jp1 = s1_opc inside {6'h1A, 6'h1E};
    both = s0_vld && issue0 && issue1;
    ld_iss = issue0 && ld0 || issue1 && ld1;
    stc_iss = issue0 && s0_opc[5:1] == 5'h17 || issue1 && s1_opc[5:1] == 5'h17;
    jmp_iss = issue0 && jp0 || issue1 && jp1;
    br_iss = issue0 && cb0 || issue1 && cb1;
  end
  default clocking dis_clk @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_slot_order: assert property (s0_vld && issue1 |-> issue0) else $error("slot1 issued alone");
  a_hold_flag: assert property (s0_vld && !issue0 |-> issue_hold) else $error("stall without hold");
  a_pair_qw: assert property (both |-> pair_same_qw) else $error("pair across quadwords");
  a_pair_mem: assert property (both |-> !((ld0 || st0) && (ld1 || st1)))
    else $error("two memory ops paired");
  a_pair_ctrl: assert property (both |-> !(cb0 && cb1)) else $error("two branches paired");
  a_trap_second: assert property (both |-> !(s1_opc == 6'h18 && s1_misc == TRAP_BARRIER))
    else $error("trap barrier second in pair");
  a_nop_stall: assert property (nop_inject |-> issue_hold && !issue0) else $error("nop without stall");
  a_stc_load: assert property (stc_iss |=> !ld_iss [*2])
    else $error("load too soon after store-conditional");
  a_jump_branch: assert property (jmp_iss |=> !br_iss) else $error("branch right after jump");
  a_lsu_hold: assert property (lsu_busy |-> !(issue0 && (ld0 || st0)) && !(issue1 && (ld1 || st1)))
    else $error("memory op while unit busy");
endmodule : dis_scoreboard_sva
bind dis_scoreboard dis_scoreboard_sva dis_scoreboard_sva_inst (.ref_clk, .resetn, .s0_vld, .s0_opc, .s0_cls,
  .s0_misc, .s1_vld, .s1_opc, .s1_cls, .s1_misc, .pair_same_qw, .lsu_busy, .issue0, .issue1, .issue_hold,
  .nop_inject);

// ==== tb/dis_mem_model.sv ====
// Bus-side model that acknowledges a memory barrier.
// Assumes mb_issue marks the cycle in which a barrier issues.
`timescale 1ns/1ns
module dis_mem_model (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       mb_issue,
  input wire logic [3:0] ack_dly,
  output logic           mb_ack
);
  logic [3:0] cnt_ff;
  assign mb_ack = cnt_ff == 4'h1;
  always_ff @(posedge ref_clk) begin
    if (!resetn) cnt_ff <= 4'h0;
    else if (mb_issue) cnt_ff <= ack_dly;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  end
endmodule : dis_mem_model

// ==== tb/dis_scoreboard_tb.sv ====
// Self-checking bench for the dual-issue scoreboard.
// Assumes a 25 MHz clock; the bench plays the decode stage.
`timescale 1ns/1ns
module dis_scoreboard_tb import dis_pkg::*;;
  typedef struct packed {logic [5:0] opc; dis_cls_t cls; dis_misc_t misc; logic [5:0] ra, rb, rc;} dis_ins_t;
  typedef struct packed {dis_ins_t a, b; logic v0, v1, qw, e0, e1;} dis_row_t;
  localparam dis_ins_t i_add = '{6'h10, ADD_LOGIC_CLASS, MISC_OTHER, 6'h01, 6'h02, 6'h03};
  localparam dis_ins_t i_shf = '{6'h12, SHIFT_CMOV_CLASS, MISC_OTHER, 6'h03, 6'h1F, 6'h05};
  localparam dis_ins_t i_sub = '{6'h10, ADD_LOGIC_CLASS, MISC_OTHER, 6'h05, 6'h06, 6'h07};
  localparam dis_ins_t i_ldq = '{6'h29, LOAD_CLASS, MISC_OTHER, 6'h1F, 6'h08, 6'h02};
  localparam dis_ins_t i_use2 = '{6'h10, ADD_LOGIC_CLASS, MISC_OTHER, 6'h02, 6'h1F, 6'h09};
  localparam dis_ins_t i_waw = '{6'h10, ADD_LOGIC_CLASS, MISC_OTHER, 6'h1F, 6'h1F, 6'h02};
  localparam dis_ins_t i_ld2 = '{6'h29, LOAD_CLASS, MISC_OTHER, 6'h1F, 6'h0A, 6'h0B};
  localparam dis_ins_t i_std = '{6'h2D, STORE_CLASS, MISC_OTHER, 6'h03, 6'h0C, 6'h1F};
  localparam dis_ins_t i_stb = '{6'h2D, STORE_CLASS, MISC_OTHER, 6'h0D, 6'h03, 6'h1F};
  localparam dis_ins_t i_br = '{6'h30, JUMP_CLASS, MISC_OTHER, 6'h1F, 6'h1F, 6'h1F};
  localparam dis_ins_t i_fbr = '{6'h31, FP_COND_BRANCH_CLASS, MISC_OTHER, 6'h21, 6'h1F, 6'h1F};
  localparam dis_ins_t i_trap = '{6'h18, NONE_CLASS, TRAP_BARRIER, 6'h1F, 6'h1F, 6'h1F};
  localparam dis_ins_t i_mb = '{6'h18, NONE_CLASS, MEMORY_BARRIER, 6'h1F, 6'h1F, 6'h1F};
  localparam dis_ins_t i_mul = '{6'h13, MUL_LONG_CLASS, MISC_OTHER, 6'h0E, 6'h0F, 6'h10};
  localparam dis_ins_t i_mul2 = '{6'h13, MUL_LONG_CLASS, MISC_OTHER, 6'h11, 6'h12, 6'h14};
  localparam dis_ins_t i_mul3 = '{6'h13, MUL_LONG_CLASS, MISC_OTHER, 6'h14, 6'h1F, 6'h19};
  localparam dis_ins_t i_jmp = '{6'h1A, JUMP_CLASS, MISC_OTHER, 6'h1F, 6'h15, 6'h1F};
  localparam dis_ins_t i_beq = '{6'h39, INT_COND_BRANCH_CLASS, MISC_OTHER, 6'h16, 6'h1F, 6'h1F};
  localparam dis_ins_t i_stc = '{6'h2F, STORE_CLASS, MISC_OTHER, 6'h17, 6'h18, 6'h1F};
  localparam dis_ins_t i_dv1 = '{6'h16, FP_DIVIDE_S_CLASS, MISC_OTHER, 6'h22, 6'h23, 6'h24};
  localparam dis_ins_t i_dv2 = '{6'h16, FP_DIVIDE_S_CLASS, MISC_OTHER, 6'h25, 6'h26, 6'h27};
  localparam dis_ins_t i_fp_operate_class = '{6'h16, FP_OPERATE_CLASS, MISC_OTHER, 6'h28, 6'h29, 6'h2A};
  dis_row_t   rows [10] = '{'{i_add, i_ld2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
    '{i_add, i_mul2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{i_add, i_ld2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, '{i_ld2, i_std, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{i_br, i_fbr, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0}, '{i_add, i_trap, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{i_add, i_std, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, '{i_add, i_stb, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{i_mul, i_add, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}, '{i_mul, i_std, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}};
  logic       ref_clk = 1'b0, resetn = 1'b0, lsu_busy = 1'b0, lsu_miss = 1'b0, lsu_fill = 1'b0;
  logic       v0 = 1'b0, v1 = 1'b0, qw = 1'b1;
  logic       mb_ack, issue0, issue1, issue_hold, nop_inject, mb_issue;
  logic [3:0] ack_dly = 4'h5;
  logic [5:0] lsu_miss_reg = 6'h00, lsu_fill_reg = 6'h00;
  dis_ins_t   i0 = i_add, i1 = i_add;
  int         err_count = 0, comparisons = 0, cyc = 0, n;
  dis_scoreboard dis_scoreboard_inst (.ref_clk, .resetn, .s0_vld(v0), .s0_opc(i0.opc), .s0_cls(i0.cls),
    .s0_misc(i0.misc), .s0_ra(i0.ra), .s0_rb(i0.rb), .s0_rc(i0.rc), .s0_ra_use(i0.ra != 6'h1F),
    .s0_rb_use(i0.rb != 6'h1F), .s0_rc_use(i0.rc != 6'h1F), .s1_vld(v1), .s1_opc(i1.opc), .s1_cls(i1.cls),
    .s1_misc(i1.misc), .s1_ra(i1.ra), .s1_rb(i1.rb), .s1_rc(i1.rc), .s1_ra_use(i1.ra != 6'h1F),
    .s1_rb_use(i1.rb != 6'h1F), .s1_rc_use(i1.rc != 6'h1F), .pair_same_qw(qw), .mb_ack, .lsu_busy, .lsu_miss,
    .lsu_miss_reg, .lsu_fill, .lsu_fill_reg, .issue0, .issue1, .issue_hold, .nop_inject);
  dis_mem_model dis_mem_model_inst (.ref_clk, .resetn, .mb_issue, .ack_dly, .mb_ack);
  assign mb_issue = issue0 && i0.opc == 6'h18 && i0.misc == MEMORY_BARRIER;
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic rst();
    resetn = 1'b0;
    tick();
    resetn = 1'b1;
  endtask : rst
  // Slot0 stays presented; returns how many cycles it was refused
  task automatic run0(input dis_ins_t i, output int cnt);
    i0 = i;
    v0 = 1'b1;
    cnt = 0;
    #20;
    while (issue0 !== 1'b1 && cnt < 100) begin
      tick();
      cnt++;
      #20;
    end
    tick();
  endtask : run0
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    foreach (rows[k]) begin
      i0 = rows[k].a;
      i1 = rows[k].b;
      v0 = rows[k].v0;
      v1 = rows[k].v1;
      qw = rows[k].qw;
      #20;
      chk(issue0, rows[k].e0);
      chk(issue1, rows[k].e1);
      tick();
      v0 = 1'b0;
      v1 = 1'b0;
      qw = 1'b1;
      rst();
    end
    run0(i_add, n);
    run0(i_shf, n);
    chk(n, 0);
    i0 = i_sub;
    #20;
    chk(nop_inject, 1);
    tick();
    run0(i_sub, n);
    chk(n, 0);
    run0(i_ldq, n);
    run0(i_use2, n);
    chk(n, 2);
    run0(i_ldq, n);
    run0(i_waw, n);
    chk(n, 2);
    run0(i_add, n);
    run0(i_stb, n);
    chk(n, 1);
    run0(i_mul, n);
    run0(i_mul2, n);
    chk(n, 18);
    run0(i_mul3, n);
    chk(n, 20);
    v0 = 1'b0;
    repeat (17) tick();
    run0(i_add, n);
    chk(n, 1);
    run0(i_dv1, n);
    run0(i_dv2, n);
    chk(n, 29);
    run0(i_stc, n);
    run0(i_ld2, n);
    chk(n, 2);
    run0(i_jmp, n);
    run0(i_beq, n);
    chk(n, 1);
    for (int d = 1; d < 6; d += 4) begin
      ack_dly = d[3:0];
      run0(i_mb, n);
      run0(i_ld2, n);
      chk(n, d);
    end
    // A load whose destination write has already landed, so only the busy unit stalls it
    lsu_busy = 1'b1;
    i0 = i_ldq;
    repeat (3) begin
      #20;
      chk(issue0, 0);
      chk(issue_hold, 1);
      chk(nop_inject, 0);
      tick();
    end
    lsu_busy = 1'b0;
    run0(i_ldq, n);
    lsu_miss = 1'b1;
    lsu_miss_reg = 6'h02;
    i0 = i_use2;
    tick();
    lsu_miss = 1'b0;
    repeat (5) begin
      #20;
      chk(issue0, 0);
      tick();
    end
    lsu_fill = 1'b1;
    lsu_fill_reg = 6'h02;
    tick();
    lsu_fill = 1'b0;
    run0(i_use2, n);
    chk(n, 0);
    // FP operate refused six and five cycles before the divide result
    run0(i_dv1, n);
    chk(n, 0);
    v0 = 1'b0;
    repeat (27) tick();
    run0(i_fp_operate_class, n);
    chk(n, 2);
    stop_test();
  end
endmodule : dis_scoreboard_tb
